// ==== hdl/txip_pkg.sv ====
// package for the four-channel transmit input front end: register map, fields, types, constants
// assumes a single 125 MHz system clock; all pins are sampled into that domain before use
// Overview of operation
// - With parity checking on, a parity error raises the channel error flag for exactly one character period.
// - A character that fails parity is replaced by the C0.7 code, in encoded and in bypass mode alike.
// - In self-test the error flag pulses once per 511 characters, plus 16 word sync characters with common rx clocking.
// - The self-test pulse lasts one period with per-channel rx clocking and seventeen with common clocking and encoder on.
// - A phase-align buffer overflow or underflow holds the error flag until a word sync goes out or phase reset is low on two rising reference edges in a row.
// - Control and data are captured on the rising edge of the transmit clock picked by the clock select; the host sets them up.
// - With the encoder bypassed, control and data together form one raw 10-bit character.
// - With the encoder on, the control field picks data, special character, K28.5 fill or word sync start.
// - The encoder is on whenever the transmit mode is not zero, and then data names the character to send.
// - With parity control not zero, odd parity is checked over data, and control too in two settings; the host supplies it.
// - In some transmit modes the shared special-character select joins the control field to pick special or word sync.
// - The shared special-character select is sampled with channel A's transmit clock when clocks are per channel.
// - In half-rate reference mode, reference-clocked inputs and outputs use both reference clock edges.
package txip_pkg;

	localparam int TXIP_NCH = 4;

	// register byte offsets
	localparam logic [3:0] TXIP_REG_CTRL = 4'h0;
	localparam logic [3:0] TXIP_REG_STATUS = 4'h4;
	localparam logic [3:0] TXIP_REG_IRQ_STAT = 4'h8;
	localparam logic [3:0] TXIP_REG_IRQ_MASK = 4'hC;

	// control register field positions
	localparam int TXIP_F_TXMODE = 0;
	localparam int TXIP_F_PARITY_CONTROL = 2;
	localparam int TXIP_F_CKSEL = 4;
	localparam int TXIP_F_RX_OUTPUT_CLOCK_SELECT = 6;
	localparam int TXIP_F_HALF = 8;
	localparam int TXIP_F_BIST = 16;
	localparam logic [31:0] TXIP_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] TXIP_CTRL_FIXED_MASK = 32'h0000_01FF;

	// self-test timing in character periods
	localparam logic [9:0] TXIP_BIST_LEN = 10'h1FF;
	localparam logic [9:0] TXIP_WSYNC_LEN = 10'h010;
	localparam logic [4:0] TXIP_PULSE_SHORT = 5'h01;
	localparam logic [4:0] TXIP_PULSE_LONG = 5'h11;

	// phase-align buffer occupancy
	localparam logic [1:0] TXIP_PAB_CENTRE = 2'h1;
	localparam logic [1:0] TXIP_PAB_FULL = 2'h2;

	// substitute character and mode details
	localparam logic [9:0] TXIP_C07_CODE = 10'h0E0;
	localparam int TXIP_SPECIAL_CHAR_SELECT_MODE_BIT = 1;

	// three-level clock select straps
	typedef enum logic [1:0] {
		TXIP_CK_LOW = 2'b00,
		TXIP_CK_MID = 2'b01,
		TXIP_CK_HIGH = 2'b11
	} txip_cksel_t;

	// what the shifter is told to send
	typedef enum logic [2:0] {
		TXIP_K_RAW = 3'h0,
		TXIP_K_DATA = 3'h1,
		TXIP_K_SPECIAL = 3'h2,
		TXIP_K_FILL = 3'h3,
		TXIP_K_WSYNC = 3'h4,
		TXIP_K_BAD = 3'h5
	} txip_kind_t;

	typedef struct packed {
		logic par;
		logic [1:0] ctl;
		logic [7:0] data;
	} txip_char_in_t;

	typedef struct packed {
		txip_kind_t kind;
		logic [9:0] code;
	} txip_char_out_t;

endpackage : txip_pkg

// ==== hdl/txip_pin_sync.sv ====
// two-flop synchroniser with edge detection for a group of pins
// assumes pins are asynchronous to clk_in; edges come from the second and third stages
`timescale 1ns/1ns
`default_nettype none
module txip_pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out,
	output logic [W-1:0] rise_out,
	output logic [W-1:0] fall_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// metastability chain plus one history stage
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end
		else
		begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// edges seen after the chain only
	assign level_out = sync_q;
	assign rise_out = sync_q & ~prev_q;
	assign fall_out = ~sync_q & prev_q;
endmodule : txip_pin_sync
`default_nettype wire

// ==== hdl/txip_input_front.sv ====
// transmit input front end: capture, parity check, self-test progress, phase-align faults
// assumes Avalon-MM master on clk_in; link clocks are slow pins sampled and edge-detected here
`timescale 1ns/1ns
`default_nettype none
module txip_input_front
	import txip_pkg::*;
#(
	parameter int NCH = TXIP_NCH
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic reference_clock_in,
	input wire logic [NCH-1:0] tx_input_clock_in,
	input wire logic tx_phase_reset_n_in,
	input wire logic special_char_select_in,
	input wire txip_char_in_t tx_char_in [NCH],
	output txip_char_out_t tx_char_out [NCH],
	output logic [NCH-1:0] tx_char_valid_out,
	output logic [NCH-1:0] tx_error_flag_out,
	output logic irq_out
);
	// elaboration check: register fields hold at most eight channels
	if (NCH < 1 || NCH > 8)
	begin : g_bad_nch
		$error("txip_input_front: NCH must be 1 to 8");
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	// shared pins: reference clock, channel clocks, phase reset, special select
	logic [NCH+2:0] misc_lvl;
	logic [NCH+2:0] misc_rise;
	logic [NCH+2:0] misc_fall;

	txip_pin_sync #(.W(NCH + 3)) u_misc_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.pin_in({special_char_select_in, tx_phase_reset_n_in, tx_input_clock_in, reference_clock_in}),
		.level_out(misc_lvl),
		.rise_out(misc_rise),
		.fall_out(misc_fall)
	);

	// control register fields
	logic [31:0] ctrl_q;
	wire logic [1:0] tx_mode_select = ctrl_q[TXIP_F_TXMODE +: 2];
	wire logic [1:0] parity_control = ctrl_q[TXIP_F_PARITY_CONTROL +: 2];
	wire txip_cksel_t tx_input_clock_select = txip_cksel_t'(ctrl_q[TXIP_F_CKSEL +: 2]);
	wire txip_cksel_t rx_output_clock_select = txip_cksel_t'(ctrl_q[TXIP_F_RX_OUTPUT_CLOCK_SELECT +: 2]);
	wire logic ref_half_rate_select = ctrl_q[TXIP_F_HALF];
	wire logic [NCH-1:0] bist_en = ctrl_q[TXIP_F_BIST +: NCH];

	// decoded modes
	wire logic ref_rise = misc_rise[0];
	wire logic char_en = ref_rise | (ref_half_rate_select & misc_fall[0]);
	wire logic [NCH-1:0] clk_rise = misc_rise[NCH:1];
	wire logic prst_lvl = misc_lvl[NCH+1];
	wire logic special_char_select_lvl = misc_lvl[NCH+2];
	wire logic enc_on = tx_mode_select != 2'b00;
	wire logic par_on = parity_control != 2'b00;
	wire logic par_ctl = parity_control[1];
	wire logic sc_mode = tx_mode_select[TXIP_SPECIAL_CHAR_SELECT_MODE_BIT];
	wire logic pab_on = (tx_input_clock_select != TXIP_CK_LOW) | ref_half_rate_select;
	wire logic rx_common = rx_output_clock_select != TXIP_CK_MID;
	wire logic [9:0] bist_last = TXIP_BIST_LEN - 10'h001 + (rx_common ? TXIP_WSYNC_LEN : 10'h000);
	wire logic [4:0] bist_plen = (rx_common && enc_on) ? TXIP_PULSE_LONG : TXIP_PULSE_SHORT;

	// phase reset seen low on two consecutive rising reference edges
	logic prst_low_q;
	wire logic realign = ref_rise & ~prst_lvl & prst_low_q;

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			prst_low_q <= 1'b0;
		else if (ref_rise)
			prst_low_q <= ~prst_lvl;
	end

	// per-channel capture strobes, special select follows channel A
	logic [NCH-1:0] cap_en;
	logic special_char_select_q;

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			special_char_select_q <= 1'b0;
		else if (cap_en[0])
			special_char_select_q <= special_char_select_lvl;
	end

	// per-channel state
	txip_char_in_t in_q [NCH];
	txip_char_in_t cs [NCH];
	txip_char_out_t out_q [NCH];
	txip_kind_t kind_w [NCH];
	logic [1:0] occ_q [NCH];
	logic [9:0] cnt_q [NCH];
	logic [4:0] plen_q [NCH];
	logic [NCH-1:0] perr;
	logic [NCH-1:0] per_q;
	logic [NCH-1:0] fault_q;
	logic [NCH-1:0] fault_ev;
	logic [NCH-1:0] bist_wrap;
	logic [NCH-1:0] valid_q;
	logic [NCH-1:0] err_q;
	logic [NCH-1:0] wsync_sent;

	for (genvar i = 0; i < NCH; i++)
	begin : g_ch
		wire logic [10:0] raw_pins;
		wire logic ovf;
		wire logic unf;
		wire logic [9:0] code_w;

		txip_pin_sync #(.W(11)) u_char_sync (
			.clk_in(clk_in),
			.reset_n_in(reset_n_in),
			.pin_in(tx_char_in[i]),
			.level_out(raw_pins),
			.rise_out(),
			.fall_out()
		);

		// capture edge per clock select
		assign cs[i] = txip_char_in_t'(raw_pins);
		assign cap_en[i] = (tx_input_clock_select == TXIP_CK_LOW) ? char_en :
			(tx_input_clock_select == TXIP_CK_MID) ? clk_rise[i] : clk_rise[0];

		// odd parity over data, plus control when selected
		assign perr[i] = par_on & ~(^{in_q[i].data, in_q[i].par} ^ (par_ctl & ^in_q[i].ctl));

		// character decode
		assign kind_w[i] = perr[i] ? TXIP_K_BAD :
			!enc_on ? TXIP_K_RAW :
			(in_q[i].ctl == 2'b00) ? TXIP_K_DATA :
			(in_q[i].ctl == 2'b01) ? TXIP_K_SPECIAL :
			(in_q[i].ctl == 2'b10) ? TXIP_K_FILL :
			(sc_mode & special_char_select_q) ? TXIP_K_WSYNC : TXIP_K_SPECIAL;
		assign code_w = perr[i] ? TXIP_C07_CODE : {in_q[i].ctl, in_q[i].data};

		// phase-align buffer occupancy and faults
		assign ovf = pab_on & cap_en[i] & ~char_en & (occ_q[i] == TXIP_PAB_FULL);
		assign unf = pab_on & char_en & ~cap_en[i] & (occ_q[i] == 2'h0);
		assign fault_ev[i] = ovf | unf;
		assign wsync_sent[i] = char_en & (kind_w[i] == TXIP_K_WSYNC);
		assign bist_wrap[i] = bist_en[i] & char_en & (cnt_q[i] == bist_last);

		// input register on the selected edge
		always_ff @(posedge clk_in)
		begin
			if (!reset_n_in)
				in_q[i] <= '0;
			else if (cap_en[i])
				in_q[i] <= cs[i];
		end

		// buffer occupancy tracking
		always_ff @(posedge clk_in)
		begin
			if (!reset_n_in || realign || !pab_on)
				occ_q[i] <= TXIP_PAB_CENTRE;
			else if (cap_en[i] && !char_en && !ovf)
				occ_q[i] <= occ_q[i] + 2'h1;
			else if (char_en && !cap_en[i] && !unf)
				occ_q[i] <= occ_q[i] - 2'h1;
		end

		// sticky buffer fault, a new fault beats the clear
		always_ff @(posedge clk_in)
		begin
			if (!reset_n_in)
				fault_q[i] <= 1'b0;
			else if (fault_ev[i])
				fault_q[i] <= 1'b1;
			else if (realign || wsync_sent[i])
				fault_q[i] <= 1'b0;
		end

		// outgoing character and parity pulse per character period
		always_ff @(posedge clk_in)
		begin
			if (!reset_n_in)
			begin
				out_q[i] <= '0;
				per_q[i] <= 1'b0;
				valid_q[i] <= 1'b0;
			end
			else
			begin
				valid_q[i] <= char_en;
				if (char_en)
				begin
					out_q[i] <= '{kind: kind_w[i], code: code_w};
					per_q[i] <= perr[i];
				end
			end
		end

		// self-test pass counter and pulse length
		always_ff @(posedge clk_in)
		begin
			if (!reset_n_in || !bist_en[i])
			begin
				cnt_q[i] <= 10'h000;
				plen_q[i] <= 5'h00;
			end
			else if (char_en)
			begin
				cnt_q[i] <= bist_wrap[i] ? 10'h000 : cnt_q[i] + 10'h001;
				plen_q[i] <= bist_wrap[i] ? bist_plen : (plen_q[i] != 5'h00 ? plen_q[i] - 5'h01 : 5'h00);
			end
		end

		// error flag from the three sources only
		always_ff @(posedge clk_in)
		begin
			if (!reset_n_in)
				err_q[i] <= 1'b0;
			else
				err_q[i] <= per_q[i] | (plen_q[i] != 5'h00) | fault_q[i];
		end

		assign tx_char_out[i] = out_q[i];

		a_capture_data: assert property (cap_en[i] |=> in_q[i] == $past(cs[i]))
			else $error("captured character differs from pins");
		a_parity_flag_pulse: assert property (char_en && perr[i] |=> per_q[i] ##1 tx_error_flag_out[i])
			else $error("parity error did not raise error flag");
		a_bad_char_subst: assert property (char_en && perr[i] |=> out_q[i].kind == TXIP_K_BAD
			&& out_q[i].code == TXIP_C07_CODE)
			else $error("bad character not substituted");
		a_raw_bypass_char: assert property (char_en && !enc_on && !perr[i] |=> out_q[i].kind == TXIP_K_RAW
			&& out_q[i].code == $past({in_q[i].ctl, in_q[i].data}))
			else $error("bypass character not raw control and data");
		a_fill_decode: assert property (char_en && enc_on && !perr[i] && in_q[i].ctl == 2'b10
			|=> out_q[i].kind == TXIP_K_FILL)
			else $error("fill control not decoded");
		a_bist_count_bound: assert property (bist_en[i] |-> cnt_q[i] <= bist_last)
			else $error("self-test counter past its period");
		a_bist_pulse_len: assert property (bist_wrap[i] && !rx_common |=> plen_q[i] == TXIP_PULSE_SHORT
			##1 tx_error_flag_out[i])
			else $error("self-test pulse length wrong");
		a_fault_hold: assert property (fault_q[i] && !realign && !wsync_sent[i] |=> fault_q[i])
			else $error("buffer fault dropped early");
		a_error_quiet: assert property (!per_q[i] && plen_q[i] == 5'h00 && !fault_q[i]
			|=> !tx_error_flag_out[i])
			else $error("error flag high with nothing pending");
		c_parity_error: cover property (char_en && perr[i]);
		c_bist_pass: cover property (bist_wrap[i]);
		c_fault_cleared: cover property (fault_q[i] ##1 !fault_q[i]);
	end

	a_special_char_select_sample: assert property (cap_en[0] |=> special_char_select_q == $past(special_char_select_lvl))
		else $error("special select not taken with channel A");

	assign tx_error_flag_out = err_q;
	assign tx_char_valid_out = valid_q;

	// Avalon slave: one wait state, then answer
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] irq_stat_q;
	logic [31:0] irq_mask_q;
	logic irq_q;
	wire logic req = avs_read_in | avs_write_in;
	wire logic wr_go = avs_write_in & ack_q;
	wire logic [31:0] wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
		{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	wire logic [31:0] ctrl_wmask = TXIP_CTRL_FIXED_MASK | (32'({NCH{1'b1}}) << TXIP_F_BIST);
	wire logic [31:0] status_w = 32'({fault_q, err_q});
	wire logic [31:0] irq_set = 32'({fault_ev, bist_wrap, char_en ? perr : {NCH{1'b0}}});
	wire logic [31:0] irq_clr = (wr_go && avs_address_in == TXIP_REG_IRQ_STAT) ? (avs_writedata_in & wmask) : 32'h0;
	wire logic [31:0] rd_mux = (avs_address_in == TXIP_REG_CTRL) ? ctrl_q :
		(avs_address_in == TXIP_REG_STATUS) ? status_w :
		(avs_address_in == TXIP_REG_IRQ_STAT) ? irq_stat_q :
		(avs_address_in == TXIP_REG_IRQ_MASK) ? irq_mask_q : 32'h0;

	assign avs_waitrequest_out = req & ~ack_q;
	assign avs_readdata_out = rdata_q;
	assign irq_out = irq_q;

	// bus handshake and read data
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (avs_read_in && !ack_q)
				rdata_q <= rd_mux;
		end
	end

	// writable registers, set beats write-one-to-clear
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			ctrl_q <= TXIP_CTRL_RESET;
			irq_mask_q <= 32'h0;
			irq_stat_q <= 32'h0;
			irq_q <= 1'b0;
		end
		else
		begin
			if (wr_go && avs_address_in == TXIP_REG_CTRL)
				ctrl_q <= (ctrl_q & ~(wmask & ctrl_wmask)) | (avs_writedata_in & wmask & ctrl_wmask);
			if (wr_go && avs_address_in == TXIP_REG_IRQ_MASK)
				irq_mask_q <= (irq_mask_q & ~wmask) | (avs_writedata_in & wmask);
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	c_bus_write: cover property (wr_go && avs_address_in == TXIP_REG_CTRL);
endmodule : txip_input_front
`default_nettype wire

// ==== testbench/txip_host_model.sv ====
// host model: makes the link clocks and presents one character per reference period
// assumes the bench supplies the next character values; parity is worked out here
`timescale 1ns/1ns
`default_nettype none
module txip_host_model
	import txip_pkg::*;
#(
	parameter int NCH = TXIP_NCH
) (
	input wire txip_char_in_t next_char_in [NCH],
	input wire logic [NCH-1:0] break_par_in,
	input wire logic par_over_ctl_in,
	input wire logic next_special_char_select_in,
	input wire logic phase_reset_req_in,
	output logic reference_clock_out,
	output logic [NCH-1:0] tx_input_clock_out,
	output txip_char_in_t tx_char_out [NCH],
	output logic special_char_select_out,
	output logic tx_phase_reset_n_out
);
	// free-running reference, phase unrelated to the system clock
	initial
	begin
		reference_clock_out = 1'b0;
		#3;
		forever #40 reference_clock_out = ~reference_clock_out;
	end
	assign tx_input_clock_out = {NCH{reference_clock_out}};
	// pins start quiet
	initial
	begin
		tx_phase_reset_n_out = 1'b1;
		special_char_select_out = 1'b0;
		for (int i = 0; i < NCH; i++)
			tx_char_out[i] = '0;
	end
	// new character on the falling edge, steady over the capturing rising edge
	always @(negedge reference_clock_out)
	begin
		special_char_select_out <= next_special_char_select_in;
		for (int i = 0; i < NCH; i++)
		begin
			tx_char_out[i].data <= next_char_in[i].data;
			tx_char_out[i].ctl <= next_char_in[i].ctl;
			tx_char_out[i].par <= ~(^next_char_in[i].data ^ (par_over_ctl_in & ^next_char_in[i].ctl)) ^ break_par_in[i];
		end
	end
	// phase reset held low over two rising reference edges, released on the third
	always @(negedge reference_clock_out)
		if (phase_reset_req_in && tx_phase_reset_n_out)
		begin
			tx_phase_reset_n_out <= 1'b0;
			repeat (3) @(posedge reference_clock_out);
			tx_phase_reset_n_out <= 1'b1;
		end
endmodule : txip_host_model
`default_nettype wire

// ==== testbench/quad_tx_input_parity_status_tb.sv ====
// self-checking bench for the transmit input front end
// assumes the host model drives the character pins and the bench owns the register bus
`timescale 1ns/1ns
`default_nettype none
module quad_tx_input_parity_status_tb
	import txip_pkg::*;
;
	localparam int NCH = TXIP_NCH;
	localparam int LIMIT = 50000;
	logic clk_in, reset_n_in, rd, wr, waitreq, irq, ref_clk, phase_n, special_char_select, next_sc, par_over, phase_req;
	logic armed, have_prev, sc_prev;
	logic [3:0] address, bad_mask;
	logic [31:0] wdata, rdata, ctrl, rng, r;
	logic [NCH-1:0] txclk, valid, flag, brk, due, exp_flag;
	txip_char_in_t next_char [NCH];
	txip_char_in_t pins [NCH];
	txip_char_in_t prev [NCH];
	txip_char_out_t outs [NCH];
	txip_char_out_t e;
	txip_char_out_t note_q [NCH][$];
	int n_mismatch, comparisons, cyc;

	txip_input_front #(.NCH(NCH)) DUT (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.avs_address_in(address),
		.avs_read_in(rd),
		.avs_write_in(wr),
		.avs_writedata_in(wdata),
		.avs_byteenable_in(4'hF),
		.avs_readdata_out(rdata),
		.avs_waitrequest_out(waitreq),
		.reference_clock_in(ref_clk),
		.tx_input_clock_in(txclk),
		.tx_phase_reset_n_in(phase_n),
		.special_char_select_in(special_char_select),
		.tx_char_in(pins),
		.tx_char_out(outs),
		.tx_char_valid_out(valid),
		.tx_error_flag_out(flag),
		.irq_out(irq)
	);
	txip_host_model #(.NCH(NCH)) host (
		.next_char_in(next_char),
		.break_par_in(brk),
		.par_over_ctl_in(par_over),
		.next_special_char_select_in(next_sc),
		.phase_reset_req_in(phase_req),
		.reference_clock_out(ref_clk),
		.tx_input_clock_out(txclk),
		.tx_char_out(pins),
		.special_char_select_out(special_char_select),
		.tx_phase_reset_n_out(phase_n)
	);

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// expected output for a captured character under the current settings
	function automatic txip_char_out_t expect_char(input txip_char_in_t c, input logic sc);
		txip_char_out_t o;
		o.code = {c.ctl, c.data};
		o.kind = TXIP_K_RAW;
		if (ctrl[1:0] != 2'h0)
			o.kind = (c.ctl == 2'h0) ? TXIP_K_DATA : (c.ctl == 2'h2) ? TXIP_K_FILL : (c.ctl == 2'h3 && ctrl[1] && sc) ? TXIP_K_WSYNC : TXIP_K_SPECIAL;
		if (ctrl[3:2] != 2'h0 && !(^c.data ^ c.par ^ (ctrl[3] & ^c.ctl)))
		begin
			o.kind = TXIP_K_BAD;
			o.code = TXIP_C07_CODE;
		end
		return o;
	endfunction : expect_char

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one Avalon transfer: hold until waitrequest is sampled low at a rising edge, then release
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_in);
		wr <= w;
		rd <= ~w;
		address <= a;
		wdata <= d;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (waitreq !== 1'b0 && n < 20);
		check("bus answer", 0, n >= 20);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus

	task automatic rd_check(input logic [3:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(what, exp, q);
	endtask : rd_check

	// new settings; comparisons paused until characters reflect them
	task automatic set_ctrl(input logic [31:0] v);
		armed <= 1'b0;
		bus(1'b1, TXIP_REG_CTRL, v, r);
		ctrl = v;
		repeat (12) @(posedge clk_in);
		armed <= 1'b1;
	endtask : set_ctrl

	// wait for the error flag of a channel, or irq when ch is negative
	task automatic wait_sig(input int ch, input logic want, input int lim, output int n);
		n = 0;
		while (((ch < 0) ? irq : flag[ch]) !== want && n < lim)
		begin
			@(posedge clk_in);
			n++;
		end
		check("wait bound", 1, n < lim);
	endtask : wait_sig

	task automatic bist_run(input logic [31:0] v, input int per, input int wid);
		int a, b, c;
		armed <= 1'b0;
		bus(1'b1, TXIP_REG_CTRL, v, r);
		ctrl = v;
		wait_sig(0, 1'b0, 400, a);
		wait_sig(0, 1'b1, 6000, a);
		wait_sig(0, 1'b0, 400, b);
		wait_sig(0, 1'b1, 6000, c);
		check("pass width", wid, b);
		check("pass period", per, b + c);
		$display("test self-test done");
	endtask : bist_run

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	initial
	begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	// random characters reach the pins; timeout guard
	always @(posedge clk_in)
	begin
		rng = xs(rng);
		for (int i = 0; i < NCH; i++)
			next_char[i] <= {1'b0, rng[7*i +: 10]};
		next_sc <= rng[31];
		brk <= rng[30:27] & bad_mask;
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			n_mismatch++;
			close_out();
		end
	end

	// note the character taken one reference period earlier
	always @(posedge ref_clk)
	begin
		for (int i = 0; i < NCH; i++)
		begin
			if (!armed)
				note_q[i].delete();
			else if (have_prev)
				note_q[i].push_back(expect_char(prev[i], sc_prev));
			prev[i] = pins[i];
		end
		have_prev = armed;
		sc_prev = special_char_select;
	end

	// compare each emitted character, then the error flag one cycle later
	always @(negedge clk_in)
		for (int i = 0; i < NCH; i++)
		begin
			if (due[i])
				check("error flag", exp_flag[i], flag[i]);
			due[i] = 1'b0;
			if (valid[i] === 1'b1 && note_q[i].size() > 0)
			begin
				e = note_q[i].pop_front();
				check("char kind", e.kind, outs[i].kind);
				if (e.kind == TXIP_K_RAW || e.kind == TXIP_K_BAD)
					check("char code", e.code, outs[i].code);
				due[i] = 1'b1;
				exp_flag[i] = (e.kind == TXIP_K_BAD);
			end
		end

	initial
	begin
		int n;
		{reset_n_in, rd, wr, armed, have_prev, par_over, phase_req, next_sc} = '0;
		{address, wdata, ctrl, bad_mask, brk, due, cyc, n_mismatch, comparisons} = '0;
		rng = 32'h0000_0023;
		repeat (16) @(posedge clk_in);
		reset_n_in <= 1'b1;
		// register reset values, access kinds, unmapped place
		rd_check(TXIP_REG_CTRL, TXIP_CTRL_RESET, "ctrl reset");
		rd_check(TXIP_REG_IRQ_MASK, 32'h0, "mask reset");
		bus(1'b1, TXIP_REG_STATUS, 32'hFFFF_FFFF, r);
		rd_check(TXIP_REG_STATUS, 32'h0, "status read only");
		rd_check(4'h2, 32'h0, "unmapped");
		bus(1'b1, TXIP_REG_CTRL, 32'hFFF0_FECF, r);
		phase_req <= 1'b1;
		rd_check(TXIP_REG_CTRL, 32'h0000_00CF, "ctrl mask");
		phase_req <= 1'b0;
		$display("test registers done");
		// every mode against parity settings 0 to 2, with broken parity mixed in
		bad_mask <= 4'hF;
		for (int m = 0; m < 4; m++)
			for (int p = 0; p < 3; p++)
			begin
				par_over <= p[1];
				set_ctrl({28'h0, p[1:0], m[1:0]});
				repeat (400) @(posedge clk_in);
				$display("test stream done");
			end
		// parity events raise the interrupt only when unmasked
		par_over <= 1'b0;
		set_ctrl(32'h0000_0005);
		bus(1'b1, TXIP_REG_IRQ_STAT, 32'hFFFF_FFFF, r);
		repeat (300) @(posedge clk_in);
		check("irq masked", 0, irq);
		rd_check(TXIP_REG_IRQ_STAT, 32'h0000_000F, "irq status");
		bus(1'b1, TXIP_REG_IRQ_MASK, 32'h0000_0001, r);
		wait_sig(-1, 1'b1, 20, n);
		bad_mask <= 4'h0;
		repeat (60) @(posedge clk_in);
		bus(1'b1, TXIP_REG_IRQ_STAT, 32'hFFFF_FFFF, r);
		rd_check(TXIP_REG_IRQ_STAT, 32'h0, "irq cleared");
		wait_sig(-1, 1'b0, 20, n);
		$display("test interrupt done");
		// buffer faults hold the flag until a phase reset realigns the buffers
		armed <= 1'b0;
		bus(1'b1, TXIP_REG_CTRL, 32'h0000_0110, r);
		repeat (100) @(posedge clk_in);
		rd_check(TXIP_REG_STATUS, 32'h0000_00FF, "fault status");
		bus(1'b1, TXIP_REG_CTRL, 32'h0000_0000, r);
		repeat (100) @(posedge clk_in);
		check("fault held", 32'h0000_000F, flag);
		phase_req <= 1'b1;
		repeat (20) @(posedge clk_in);
		phase_req <= 1'b0;
		wait_sig(0, 1'b0, 100, n);
		rd_check(TXIP_REG_STATUS, 32'h0000_0000, "fault cleared");
		$display("test buffer fault done");
		// self-test progress with per-channel and common receive clocking
		bist_run(32'h0001_0041, 5110, 10);
		bist_run(32'h0001_0001, 5270, 170);
		close_out();
	end
endmodule : quad_tx_input_parity_status_tb
`default_nettype wire
